// ==== core/card_io_window_cycle_control.sv ====
// Socket I/O window registers and the resolver that claims host I/O cycles for the card.
// Assumes the register port and I/O request come from logic on this clock; the card
// sizing pin is asynchronous and is synchronised here.
`timescale 1ns/100ps
module card_io_window_cycle_control
  import card_io_pkg::*;
#(
  parameter logic [1:0] LEGACY_BANK = LEGACY_BANK_A
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_legacy,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_ack_q,
  input wire logic card_iois16,
  input wire logic io_req,
  input wire logic [15:0] io_addr,
  output logic io_done_q,
  output logic io_claim_q,
  output logic io_window_q,
  output logic io_wide_q,
  output logic [3:0] io_cycle_len_q
);

  // Map either address space onto a register index; bit 4 flags a hit
  function automatic logic [4:0] reg_decode(input logic legacy, input logic [11:0] addr);
    logic [11:0] ofs;
    logic space_ok;
    ofs = legacy ? {REG_PAGE_LEGACY, addr[5:0]} : addr;
    space_ok = !legacy || ((addr[11:8] == 4'h0) && (addr[7:6] == LEGACY_BANK));
    if (space_ok && (ofs[11:4] == REG_PAGE) && (ofs[3:0] >= IDX_FIRST)) begin
      reg_decode = {1'b1, ofs[3:0]};
    end else begin
      reg_decode = 5'h00;
    end
  endfunction : reg_decode

  logic [7:0] bank_q [REG_IDX_FIRST:REG_IDX_LAST]; // Window register bytes 806h..80Fh
  logic iois16_meta_q;                            // First synchroniser stage
  logic iois16_sync_q;                            // Synchronised card sizing level
  res_state_t state_q;                            // Resolver state
  res_state_t state_d;
  logic [15:0] addr_q;                            // Address under resolution
  win_cfg_t cfg [2];                              // Per-window configuration
  win_res_t res [2];                              // Per-window match result

  // Write and read selection, both decoded from the same address; the strobes qualify them later
  wire [4:0] wr_sel = reg_decode(reg_legacy, reg_addr);
  wire [4:0] rd_sel = reg_decode(reg_legacy, reg_addr);
  wire wr_hit = reg_wr && wr_sel[4];
  wire [3:0] wr_idx = wr_sel[3:0];
  // Reserved enable bit is kept at zero so it always reads back zero
  wire [7:0] wr_data = (wr_idx == IDX_WIN_ENABLE) ? (reg_wdata & ENABLE_WMASK) : reg_wdata;
  // Unmapped reads return zero
  wire [7:0] rd_data = rd_sel[4] ? bank_q[rd_sel[3:0]] : REG_RESET;
  wire [7:0] ctrl_q = bank_q[IDX_CYCLE_CTRL];
  wire [7:0] enable_q = bank_q[IDX_WIN_ENABLE];

  // Register bank: all bytes reset to zero, control byte is fully writable
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = REG_IDX_FIRST; i <= REG_IDX_LAST; i++) begin
        bank_q[i] <= REG_RESET;
      end
    end else if (wr_hit) begin
      bank_q[wr_idx] <= wr_data;
    end
  end

  // Read port answers one cycle after either strobe
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata_q <= REG_RESET;
      reg_ack_q <= 1'b0;
    end else begin
      reg_rdata_q <= reg_rd ? rd_data : REG_RESET;
      reg_ack_q <= reg_rd || reg_wr;
    end
  end

  // Sizing pin comes straight from the card, so it is synchronised first
  always_ff @(posedge clock) begin
    if (!resetn) begin
      iois16_meta_q <= 1'b0;
      iois16_sync_q <= 1'b0;
    end else begin
      iois16_meta_q <= card_iois16;
      iois16_sync_q <= iois16_meta_q;
    end
  end

  // Build each window's configuration from its bytes and control nibble
  generate
    for (genvar w = 0; w < 2; w++) begin : g_win
      assign cfg[w].enable = enable_q[EN_BIT_W0 + w];
      assign cfg[w].start = {bank_q[IDX_START_HI_W0 + w * WIN_REG_STRIDE],
                             bank_q[IDX_START_LO_W0 + w * WIN_REG_STRIDE]};
      assign cfg[w].stop = {bank_q[IDX_END_HI_W0 + w * WIN_REG_STRIDE],
                            bank_q[IDX_END_LO_W0 + w * WIN_REG_STRIDE]};
      assign cfg[w].auto_width = ctrl_q[FLD_AUTO_WIDTH + w * WIN_FIELD_STRIDE];
      assign cfg[w].fixed_wide = ctrl_q[FLD_FIXED_WIDTH + w * WIN_FIELD_STRIDE];
      assign cfg[w].short8 = ctrl_q[FLD_SHORT8 + w * WIN_FIELD_STRIDE];
      assign cfg[w].wait16 = ctrl_q[FLD_WAIT16 + w * WIN_FIELD_STRIDE];

      card_io_window_match u_match (
        .cfg(cfg[w]),
        .addr(addr_q),
        .card_wide(iois16_sync_q),
        .res(res[w])
      );
    end
  endgenerate

  // Window 0 wins when both windows cover the address
  wire pick_w1 = !res[0].hit && res[1].hit;
  wire any_hit = res[0].hit || res[1].hit;
  win_res_t pick;
  assign pick = pick_w1 ? res[1] : res[0];

  // Resolver: take a request in idle, answer it the next cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (io_req) begin
          state_d = ST_RESOLVE;
        end
      end
      ST_RESOLVE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Latch the address only when a request is taken
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      addr_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE && io_req) begin
        addr_q <= io_addr;
      end
    end
  end

  // Result outputs: a one-cycle done pulse; claim and shape load on the same edge and stand until the next answer
  always_ff @(posedge clock) begin
    if (!resetn) begin
      io_done_q <= 1'b0;
      io_claim_q <= 1'b0;
      io_window_q <= 1'b0;
      io_wide_q <= 1'b0;
      io_cycle_len_q <= 4'h0;
    end else begin
      io_done_q <= (state_q == ST_RESOLVE);
      if (state_q == ST_RESOLVE) begin
        io_claim_q <= any_hit;
        io_window_q <= pick_w1;
        io_wide_q <= pick.wide;
        io_cycle_len_q <= pick.len;
      end
    end
  end

  wire claim0 = io_done_q && io_claim_q && !io_window_q;
  wire claim1 = io_done_q && io_claim_q && io_window_q;

  chk_ctrl_reset_zero: assert property (@(posedge clock) !resetn |=> ctrl_q == REG_RESET)
    else $error("Control register not zero after reset");

  chk_ctrl_write_back: assert property (@(posedge clock) disable iff (!resetn)
    reg_wr && wr_sel == {1'b1, IDX_CYCLE_CTRL} |=> ctrl_q == $past(reg_wdata))
    else $error("Control register write not stored");

  chk_win0_len16: assert property (@(posedge clock) disable iff (!resetn)
    claim0 && io_wide_q |-> io_cycle_len_q ==
      ($past(ctrl_q[FLD_WAIT16]) ? LEN_EXT16 : LEN_STD16))
    else $error("Window 0 16-bit length wrong");

  chk_win1_len16: assert property (@(posedge clock) disable iff (!resetn)
    claim1 && io_wide_q |-> io_cycle_len_q ==
      ($past(ctrl_q[FLD_WAIT16 + WIN_FIELD_STRIDE]) ? LEN_EXT16 : LEN_STD16))
    else $error("Window 1 16-bit length wrong");

  chk_win0_len8: assert property (@(posedge clock) disable iff (!resetn)
    claim0 && !io_wide_q |-> io_cycle_len_q ==
      ($past(ctrl_q[FLD_SHORT8]) ? LEN_SHORT8 : LEN_STD8))
    else $error("Window 0 8-bit length wrong");

  chk_win1_len8: assert property (@(posedge clock) disable iff (!resetn)
    claim1 && !io_wide_q |-> io_cycle_len_q ==
      ($past(ctrl_q[FLD_SHORT8 + WIN_FIELD_STRIDE]) ? LEN_SHORT8 : LEN_STD8))
    else $error("Window 1 8-bit length wrong");

  chk_win0_width: assert property (@(posedge clock) disable iff (!resetn)
    claim0 |-> io_wide_q == ($past(ctrl_q[FLD_AUTO_WIDTH]) ? $past(iois16_sync_q)
                                                          : $past(ctrl_q[FLD_FIXED_WIDTH])))
    else $error("Window 0 width source wrong");

  chk_win1_width: assert property (@(posedge clock) disable iff (!resetn)
    claim1 |-> io_wide_q ==
      ($past(ctrl_q[FLD_AUTO_WIDTH + WIN_FIELD_STRIDE]) ? $past(iois16_sync_q)
                                                       : $past(ctrl_q[FLD_FIXED_WIDTH +
                                                                      WIN_FIELD_STRIDE])))
    else $error("Window 1 width source wrong");

  // The window select is taken now; a past copy of it would name the previous answer
  chk_claim_enabled: assert property (@(posedge clock) disable iff (!resetn)
    io_done_q && io_claim_q |-> (io_window_q ? $past(enable_q[EN_BIT_W0 + 1])
                                             : $past(enable_q[EN_BIT_W0])))
    else $error("Cycle claimed by a disabled window");

  chk_req_answer: assert property (@(posedge clock) disable iff (!resetn)
    state_q == ST_IDLE && io_req |-> ##2 io_done_q)
    else $error("Request not answered in two cycles");

endmodule : card_io_window_cycle_control

// ==== core/card_io_window_match.sv ====
// One I/O window: address match plus data width and cycle length for the card cycle.
// Assumes a settled configuration and a synchronised card sizing level; purely combinational.
`timescale 1ns/100ps
module card_io_window_match
  import card_io_pkg::*;
(
  input win_cfg_t cfg,
  input wire logic [15:0] addr,
  input wire logic card_wide,
  output win_res_t res
);

  // Inclusive range check, gated by the window enable
  wire in_range = (addr >= cfg.start) && (addr <= cfg.stop);
  // A disabled window never claims, whatever its addresses hold
  assign res.hit = cfg.enable && in_range;

  // Width comes from the sizing pin when automatic, else from the fixed bit
  assign res.wide = cfg.auto_width ? card_wide : cfg.fixed_wide;

  // Extra wait touches 16-bit cycles only, the short form 8-bit cycles only
  assign res.len = res.wide ? (cfg.wait16 ? LEN_EXT16 : LEN_STD16)
                            : (cfg.short8 ? LEN_SHORT8 : LEN_STD8);

endmodule : card_io_window_match

// ==== pkg/card_io_pkg.sv ====
// Shared constants and types for the card I/O window cycle control block.
// Assumes one socket per instance, byte-wide register access and 16-bit host I/O addresses.
package card_io_pkg;

  // Register space: offsets from the socket register base
  localparam logic [7:0] REG_PAGE = 8'h80;          // Upper byte of the window register page
  localparam logic [5:0] REG_PAGE_LEGACY = 6'h20;   // Page seen from the legacy index space
  localparam int REG_IDX_FIRST = 6;                 // Lowest register held here (806h)
  localparam int REG_IDX_LAST = 15;                 // Highest register held here (80Fh)
  localparam logic [3:0] IDX_FIRST = 4'h6;          // Same, as a comparable field
  localparam logic [11:0] OFS_WIN_ENABLE = 12'h806; // Window enable register
  localparam logic [11:0] OFS_CYCLE_CTRL = 12'h807; // Window cycle control register
  localparam logic [11:0] OFS_W0_START_LO = 12'h808; // Window 0 start low byte
  localparam logic [11:0] OFS_W0_START_HI = 12'h809; // Window 0 start high byte
  localparam logic [11:0] OFS_W1_START_LO = 12'h80C; // Window 1 start low byte
  localparam logic [11:0] OFS_W1_START_HI = 12'h80D; // Window 1 start high byte
  localparam logic [3:0] IDX_WIN_ENABLE = 4'h6;     // Register index of the enable register
  localparam logic [3:0] IDX_CYCLE_CTRL = 4'h7;     // Register index of the control register
  localparam int IDX_START_LO_W0 = 8;               // Window 0 start low index
  localparam int IDX_START_HI_W0 = 9;               // Window 0 start high index
  localparam int IDX_END_LO_W0 = 10;                // Window 0 end low index
  localparam int IDX_END_HI_W0 = 11;                // Window 0 end high index
  localparam int WIN_REG_STRIDE = 4;                // Window 1 registers sit four above

  // Legacy index space: bits 7:6 of the index pick the socket
  localparam logic [1:0] LEGACY_BANK_A = 2'h0;      // Indexes 00h..3Fh
  localparam logic [1:0] LEGACY_BANK_B = 2'h1;      // Indexes 40h..7Fh

  // Field positions inside the cycle control register, per window nibble
  localparam int FLD_FIXED_WIDTH = 0;               // Fixed width: 0 = 8 bits, 1 = 16 bits
  localparam int FLD_AUTO_WIDTH = 1;                // Width taken from the card sizing pin
  localparam int FLD_SHORT8 = 2;                    // Shortened 8-bit cycle
  localparam int FLD_WAIT16 = 3;                    // Extra wait on 16-bit cycles
  localparam int WIN_FIELD_STRIDE = 4;              // Window 1 fields sit four bits up
  localparam int EN_BIT_W0 = 6;                     // Window 0 enable; window 1 is one above
  localparam logic [7:0] ENABLE_WMASK = 8'hDF;      // Bit 5 of the enable register is reserved
  localparam logic [7:0] REG_RESET = 8'h00;         // Every register resets to zero

  // Card cycle lengths in legacy bus clocks
  localparam logic [3:0] LEN_STD8 = 4'h6;           // Standard 8-bit cycle
  localparam logic [3:0] LEN_SHORT8 = 4'h3;         // Shortened 8-bit cycle
  localparam logic [3:0] LEN_STD16 = 4'h3;          // Standard 16-bit cycle
  localparam logic [3:0] LEN_WAIT = 4'h1;           // One added wait state
  localparam logic [3:0] LEN_EXT16 = LEN_STD16 + LEN_WAIT; // Lengthened 16-bit cycle

  // Everything one window needs to claim and shape a card cycle
  typedef struct packed {
    logic enable;         // Window enable
    logic [15:0] start;   // First address claimed
    logic [15:0] stop;    // Last address claimed
    logic auto_width;     // Width follows the card sizing pin
    logic fixed_wide;     // Fixed width is 16 bits
    logic short8;         // Short 8-bit cycles
    logic wait16;         // Extra wait on 16-bit cycles
  } win_cfg_t;

  // Result of a window match
  typedef struct packed {
    logic hit;            // Address lies inside an enabled window
    logic wide;           // Card cycle is 16 bits
    logic [3:0] len;      // Card cycle length in legacy bus clocks
  } win_res_t;

  // Request resolver states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESOLVE = 2'b10
  } res_state_t;

endpackage : card_io_pkg

// ==== verif/card_sizing_model.sv ====
// Behavioural model of the 16-bit card's I/O sizing output toward the socket.
// Assumes the bench tells it which width the card decodes; the pin is not tied to the host clock.
`timescale 1ns/100ps
module card_sizing_model #(
  parameter int DELAY_NS = 3 // Card decode delay; raise it to model a slow card
)
(
  input wire logic want_wide, // Width the card's decoder reports
  output logic card_iois16 // Sizing pin, high means a 16-bit port
);
  // Start as an 8-bit card so the synchroniser never sees an unknown level
  initial begin
    card_iois16 = 1'b0;
  end

  // The pin follows the decoder after its delay, off any host clock edge
  always @(want_wide) begin
    card_iois16 <= #(DELAY_NS) want_wide;
  end
endmodule : card_sizing_model

// ==== verif/tb.sv ====
// Self-checking testbench for the card I/O window cycle control block.
// Assumes socket A decode and the card sizing model on the sizing pin.
`timescale 1ns/100ps
module tb
  import card_io_pkg::*;
;
  logic clock = 1'b0; // 125 MHz clock
  logic resetn = 1'b0; // Synchronous reset, active low
  logic reg_wr = 1'b0; // Register write strobe
  logic reg_rd = 1'b0; // Register read strobe
  logic reg_legacy = 1'b0; // Legacy index decode select
  logic [11:0] reg_addr = 12'h000; // Offset or index
  logic [7:0] reg_wdata = 8'h00; // Write data
  logic io_req = 1'b0; // Host I/O request
  logic [15:0] io_addr = 16'h0000; // Host I/O address
  logic want_wide = 1'b0; // Width the card reports
  wire card_iois16; // Sizing pin from the card
  logic [7:0] reg_rdata_q;
  logic reg_ack_q;
  logic io_done_q, io_claim_q, io_window_q, io_wide_q;
  logic [3:0] io_cycle_len_q;
  int n_errors = 0; // Mismatches seen
  int checks_done = 0; // Comparisons made
  int cycles = 0; // Cycles since start, for the hang guard

  card_io_window_cycle_control #(.LEGACY_BANK(LEGACY_BANK_A)) u_card_io_window_cycle_control (
    .clock(clock), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_legacy(reg_legacy), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q), .card_iois16(card_iois16),
    .io_req(io_req), .io_addr(io_addr), .io_done_q(io_done_q), .io_claim_q(io_claim_q),
    .io_window_q(io_window_q), .io_wide_q(io_wide_q), .io_cycle_len_q(io_cycle_len_q));

  card_sizing_model #(.DELAY_NS(3)) u_card_sizing_model (
    .want_wide(want_wide), .card_iois16(card_iois16));

  // Free-running clock, 8 ns period
  always #4 clock = ~clock;

  // Verdict and end of run, the single exit point
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      $display("ERROR run_time expected finish seen hang");
      close_out();
    end
  end

  // Compare one value; four-state so an unknown never matches
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One register access; the answer is sampled mid-cycle after the taking edge
  task automatic reg_acc(input logic wr, input logic leg, input logic [11:0] a,
                         input logic [7:0] d, input logic [7:0] exp);
    @(posedge clock);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_legacy <= leg;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("reg_ack_q", 16'h0001, {15'h0000, reg_ack_q});
    if (!wr) begin
      chk("reg_rdata_q", {8'h00, exp}, {8'h00, reg_rdata_q});
    end
  endtask : reg_acc

  // Offset-space write
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_acc(1'b1, 1'b0, a, d, 8'h00);
  endtask : wr

  // Offset-space read with expected value
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    reg_acc(1'b0, 1'b0, a, 8'h00, exp);
  endtask : rd

  // One host I/O request; the result must land exactly two cycles on
  task automatic io_acc(input logic [15:0] a, input logic claim, input logic win,
                        input logic wide, input logic [3:0] len);
    int n;
    @(posedge clock);
    io_req <= 1'b1;
    io_addr <= a;
    @(posedge clock);
    io_req <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (io_done_q !== 1'b1 && n < 4);
    chk("io_done_delay", 16'd2, 16'(n));
    chk("io_claim_q", {15'h0000, claim}, {15'h0000, io_claim_q});
    // Window, width and length only mean something on a claim
    if (claim) begin
      chk("io_window_q", {15'h0000, win}, {15'h0000, io_window_q});
      chk("io_wide_q", {15'h0000, wide}, {15'h0000, io_wide_q});
      chk("io_cycle_len_q", {12'h000, len}, {12'h000, io_cycle_len_q});
    end
  endtask : io_acc

  // Expected card cycle length from one window nibble and the pin level
  function automatic logic [3:0] want_len(input logic [3:0] nib, input logic pin);
    logic w;
    w = nib[FLD_AUTO_WIDTH] ? pin : nib[FLD_FIXED_WIDTH];
    if (w) begin
      return nib[FLD_WAIT16] ? LEN_STD16 + LEN_WAIT : LEN_STD16;
    end
    return nib[FLD_SHORT8] ? LEN_SHORT8 : LEN_STD8;
  endfunction : want_len

  // Register offsets with their socket A legacy indexes
  logic [11:0] offs [3] = '{12'h807, 12'h808, 12'h80C};
  logic [11:0] idxs [3] = '{12'h007, 12'h008, 12'h00C};
  // Window 0 spans 0120h..01FFh, window 1 spans 0340h..0347h
  logic [19:0] setup [8] = '{20'h80820, 20'h80901, 20'h80AFF, 20'h80B01,
                             20'h80C40, 20'h80D03, 20'h80E47, 20'h80F03};
  // Boundary probes: address, claim, window
  logic [17:0] probes [8] = '{{16'h011F, 2'b00}, {16'h0120, 2'b10}, {16'h01FF, 2'b10},
                              {16'h0200, 2'b00}, {16'h033F, 2'b00}, {16'h0340, 2'b11},
                              {16'h0347, 2'b11}, {16'h0348, 2'b00}};

  // Main sequence
  initial begin
    logic [3:0] nib;
    logic pin;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 8'h00);
    // Every bit both ways, through both decodes
    foreach (offs[i]) begin
      wr(offs[i], 8'hA5);
      rd(offs[i], 8'hA5);
      reg_acc(1'b1, 1'b1, idxs[i], 8'h5A, 8'h00);
      rd(offs[i], 8'h5A);
      reg_acc(1'b0, 1'b1, idxs[i], 8'h00, 8'h5A);
    end
    // Socket B index is not ours, nor is an offset past the window page
    reg_acc(1'b1, 1'b1, 12'h047, 8'hFF, 8'h00);
    rd(OFS_CYCLE_CTRL, 8'h5A);
    reg_acc(1'b0, 1'b1, 12'h047, 8'h00, 8'h00);
    wr(12'h810, 8'hFF);
    rd(12'h810, 8'h00);
    // Program both windows while still disabled
    foreach (setup[i]) wr(setup[i][19:8], setup[i][7:0]);
    wr(OFS_CYCLE_CTRL, 8'h00);
    io_acc(16'h0150, 1'b0, 1'b0, 1'b0, 4'h0);
    io_acc(16'h0340, 1'b0, 1'b0, 1'b0, 4'h0);
    wr(OFS_WIN_ENABLE, 8'hC0);
    foreach (probes[i]) begin
      io_acc(probes[i][17:2], probes[i][1], probes[i][0], 1'b0, LEN_STD8);
    end
    // One window off at a time
    wr(OFS_WIN_ENABLE, 8'h80);
    io_acc(16'h0120, 1'b0, 1'b0, 1'b0, 4'h0);
    io_acc(16'h0340, 1'b1, 1'b1, 1'b0, LEN_STD8);
    wr(OFS_WIN_ENABLE, 8'h40);
    io_acc(16'h0340, 1'b0, 1'b0, 1'b0, 4'h0);
    wr(OFS_WIN_ENABLE, 8'hC0);
    // Every control nibble at both pin levels; the other window holds the inverse
    for (int w = 0; w < 2; w++) begin
      for (int v = 0; v < 32; v++) begin
        nib = v[3:0];
        pin = v[4];
        want_wide <= pin;
        wr(OFS_CYCLE_CTRL, (w == 1) ? {nib, ~nib} : {~nib, nib});
        io_acc((w == 1) ? 16'h0345 : 16'h0150, 1'b1, w[0], nib[1] ? pin : nib[0],
               want_len(nib, pin));
      end
    end
    close_out();
  end
endmodule : tb
